// ===== src/cdb_pkg.sv
package cdb_pkg;
    localparam int DATA_W = 16;
    localparam int SEL_W = 3;
    localparam int NUM_SEL = 8;
    localparam int NUM_SYS_INT = 4;
    localparam int CNT_W = 4;
    // avalon register byte offsets
    localparam logic [3:0] OFS_COMMAND = 4'h0;
    localparam logic [3:0] OFS_STATUS = 4'h4;
    localparam logic [3:0] OFS_DATA = 4'h8;
    localparam logic [3:0] OFS_SELECT = 4'hC;
    // command word fields
    localparam int CMD_RESET_BIT = 15;
    localparam int CMD_RDY_IE_BIT = 14;
    localparam int CMD_MIX_IE_BIT = 11;
    localparam int CMD_PRE_BIT = 10;
    localparam int CMD_SEL_EN_BIT = 9;
    localparam int CMD_SEL_LSB = 6;
    // status word fields
    localparam int STS_SEL_LSB = 13;
    localparam int STS_PRE_BIT = 12;
    localparam int STS_RDY_IE_BIT = 11;
    localparam int STS_IE_LSB = 8;
    localparam int STS_RDY_INT_BIT = 7;
    localparam int STS_READY_BIT = 6;
    localparam int STS_INT_LSB = 0;
    // reset values and counts
    localparam logic [2:0] SEL_RESET = 3'h0;
    localparam logic [3:0] CLR_CNT_MAX = 4'hF;
    localparam logic [3:0] CLR_CNT_RESET = 4'h0;
    localparam logic [15:0] DATA_RESET = 16'h0000;
    localparam logic [5:0] CTRL_RESET = 6'h00;
    localparam int CPU_HOLD_CYCLES = 2;
    typedef enum logic [1:0] {
        CDB_IDLE,
        CDB_WAIT,
        CDB_DONE
    } cdb_bus_state_type;
endpackage

// ===== src/cdb_bridge.sv
// Notes on behaviour
// - command write loads select code only if select enable set; upper bits always.
// - select code decoded one-hot, registered to select lines on bus access.
// - reset clears select code to zero, only select line zero active.
// - command with top bit loads counter zero; count to 15; clear active until terminal.
// - clear counter reaches terminal state after reset, giving redundant clear meanwhile.
// - cpu read returns status when qualifier 0, input data when 1.
// - internal bus read strobe captures exchange bus word into input data register.
// - cpu data write loads output register; driven on exchange bus during write.
// - handshake flip-flops follow acknowledge transitions one clock later.
// - cpu data write strobe starts internal write handshake.
// - finished cpu data read starts prefetch of the next word.
// - prefetch command starts read at once; both requests ORed into read flop.
// - cpu ready low while bus cycle pending or active, ack active, or clear.
// - data and status done pulses, one clock, from two read sync stages.
// - rising edge of inverted interrupt input sets its flag via one-clock pulse.
// - flags 0-3 ORed into common interrupt, gated by its enable.
// - interrupt flags cleared when cpu status read completes.
// - during cpu read, flags cannot set and edge detectors hold.
// - ready rise sets ready interrupt flag, forwarded only when enabled.
// - after valid ack, strobe fall is followed by clearing of pending flag and ack valid flag.
// - command write strobe is one clock pulse from two write sync stages.
// - status ready bit 6 is zero while busy, one when transfers may proceed.
// - programmed reset bit resets block and display, other bits ignored.
module cdb_bridge (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic cpu_write_n,
    input wire logic cpu_read_n,
    input wire logic cpu_cmd_n,
    input wire logic [cdb_pkg::DATA_W-1:0] cpu_data_in,
    output logic [cdb_pkg::DATA_W-1:0] cpu_data_out,
    output logic cpu_data_oe,
    output logic cpu_ready_n,
    output logic cpu_int,
    input wire logic [cdb_pkg::DATA_W-1:0] bus_data_in,
    output logic [cdb_pkg::DATA_W-1:0] bus_data_out,
    output logic bus_data_drive_enable,
    output logic bus_write_line_n,
    output logic bus_read_line_n,
    input wire logic bus_acknowledge_n,
    output logic [cdb_pkg::NUM_SEL-1:0] system_select_lines_n,
    input wire logic [cdb_pkg::NUM_SYS_INT-1:0] sys_int_n,
    output logic programmed_clear_n
);
    import cdb_pkg::*;

    function automatic logic [NUM_SEL-1:0] decode_sel(input logic [SEL_W-1:0] code);
        logic [NUM_SEL-1:0] v;
        v = '0;
        v[code] = 1'b1;
        return v;
    endfunction

    // two-stage synchronisers for cpu pins
    logic wr_s1_r, wr_s2_r, wr_s3_r;
    logic rd_s1_r, read_sync_stage1, read_sync_stage2;
    logic cmd_s1_r, cmd_s2_r;
    logic [NUM_SYS_INT-1:0] int_s1_r, int_s2_r;

    // stage three only marks the write edge; nothing reads a first stage but its second
    always_ff @(posedge sys_clk) begin
        wr_s1_r <= ~cpu_write_n;
        wr_s2_r <= wr_s1_r;
        wr_s3_r <= wr_s2_r;
    end

    always_ff @(posedge sys_clk) begin
        rd_s1_r <= ~cpu_read_n;
        read_sync_stage1 <= rd_s1_r;
        read_sync_stage2 <= read_sync_stage1;
    end

    always_ff @(posedge sys_clk) begin
        cmd_s1_r <= ~cpu_cmd_n;
        cmd_s2_r <= cmd_s1_r;
    end

    always_ff @(posedge sys_clk) begin
        int_s1_r <= ~sys_int_n;
        int_s2_r <= int_s1_r;
    end

    // software strobes from avalon merge with pin strobes
    logic sw_cmd_wr, sw_data_wr;
    logic command_write_strobe, data_write_strobe;
    logic data_read_done, status_read_done, cpu_read_active;
    logic pin_wr_pulse;
    logic [DATA_W-1:0] wr_word;

    assign pin_wr_pulse = wr_s2_r & ~wr_s3_r;
    assign sw_cmd_wr = avs_write & (avs_address == OFS_COMMAND);
    assign sw_data_wr = avs_write & (avs_address == OFS_DATA);
    assign command_write_strobe = (pin_wr_pulse & cmd_s2_r) | sw_cmd_wr;
    assign data_write_strobe = (pin_wr_pulse & ~cmd_s2_r) | sw_data_wr;
    assign wr_word = sw_cmd_wr | sw_data_wr ? avs_writedata[DATA_W-1:0] : cpu_data_in;
    // qualifier is high for data; read ends when stage1 falls
    assign data_read_done = ~cmd_s2_r & ~read_sync_stage1 & read_sync_stage2;
    assign status_read_done = cmd_s2_r & ~read_sync_stage1 & read_sync_stage2;
    assign cpu_read_active = read_sync_stage1 | read_sync_stage2;

    // programmed clear counter; powers up into the counting state
    logic [CNT_W-1:0] clr_cnt_r;
    logic clear_counter_load, internal_clear;
    assign clear_counter_load = command_write_strobe & wr_word[CMD_RESET_BIT];
    assign programmed_clear_n = (clr_cnt_r == CLR_CNT_MAX);
    assign internal_clear = rst | ~programmed_clear_n;
    // a new load restarts the full count, so a repeated clear is never cut short

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            clr_cnt_r <= CLR_CNT_RESET;
        end else if (clear_counter_load) begin
            clr_cnt_r <= CLR_CNT_RESET;
        end else if (clr_cnt_r != CLR_CNT_MAX) begin
            clr_cnt_r <= clr_cnt_r + 4'h1;
        end
    end

    // command register
    logic [SEL_W-1:0] sel_code_r;
    logic [5:0] ctrl_r;
    logic cmd_ok;
    assign cmd_ok = command_write_strobe & ~wr_word[CMD_RESET_BIT];

    always_ff @(posedge sys_clk) begin
        if (internal_clear) begin
            sel_code_r <= SEL_RESET;
            ctrl_r <= CTRL_RESET;
        end else if (cmd_ok) begin
            ctrl_r <= wr_word[DATA_W-1:CMD_PRE_BIT];
            if (wr_word[CMD_SEL_EN_BIT]) begin
                sel_code_r <= wr_word[CMD_SEL_LSB +: SEL_W];
            end
        end
    end

    logic prefetch_bit, ready_interrupt_enable, common_interrupt_enable;
    assign prefetch_bit = ctrl_r[0];
    assign common_interrupt_enable = ctrl_r[CMD_MIX_IE_BIT-CMD_PRE_BIT];
    assign ready_interrupt_enable = ctrl_r[CMD_RDY_IE_BIT-CMD_PRE_BIT];

    // handshake flops
    logic write_pend_r, read_pend_r, prefetch_read_request;
    logic bus_write_strobe, bus_read_strobe;
    logic ack_d_r, ack_valid_r, cyc_wr_r;
    logic read_request, ack, hs_start, hs_end;
    cdb_bus_state_type hs_state_r;
    assign ack = ~bus_acknowledge_n;
    assign prefetch_read_request = cmd_ok & wr_word[CMD_PRE_BIT];
    assign read_request = prefetch_read_request | data_read_done;
    // acknowledge of the last transfer must be gone in both stages before a new strobe
    assign hs_start = (hs_state_r == CDB_IDLE) & ~ack & ~ack_d_r
        & (write_pend_r | read_pend_r);
    assign hs_end = (hs_state_r == CDB_DONE) & ack_valid_r;

    always_ff @(posedge sys_clk) begin
        ack_d_r <= internal_clear ? 1'b0 : ack;
    end

    always_ff @(posedge sys_clk) begin
        if (internal_clear) begin
            hs_state_r <= CDB_IDLE;
        end else begin
            case (hs_state_r)
                CDB_IDLE: begin
                    if (hs_start) begin
                        hs_state_r <= CDB_WAIT;
                    end
                end
                CDB_WAIT: begin
                    if (ack_d_r) begin
                        hs_state_r <= CDB_DONE;
                    end
                end
                CDB_DONE: begin
                    if (!ack_d_r) begin
                        hs_state_r <= CDB_IDLE;
                    end
                end
                default: hs_state_r <= CDB_IDLE;
            endcase
        end
    end

    // a write waiting beside a read goes first; the cycle kind decides which flag drops
    always_ff @(posedge sys_clk) begin
        if (internal_clear) begin
            cyc_wr_r <= 1'b0;
        end else if (hs_start) begin
            cyc_wr_r <= write_pend_r;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (internal_clear) begin
            bus_write_strobe <= 1'b0;
            bus_read_strobe <= 1'b0;
        end else if (hs_start) begin
            bus_write_strobe <= write_pend_r;
            bus_read_strobe <= ~write_pend_r;
        end else if (hs_state_r == CDB_WAIT && ack_d_r) begin
            bus_write_strobe <= 1'b0;
            bus_read_strobe <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (internal_clear) begin
            ack_valid_r <= 1'b0;
        end else if (hs_state_r == CDB_WAIT && ack_d_r) begin
            ack_valid_r <= 1'b1;
        end else if (hs_end) begin
            ack_valid_r <= 1'b0;
        end
    end

    // a new request in the closing cycle keeps its flag: the set wins
    always_ff @(posedge sys_clk) begin
        if (internal_clear) begin
            write_pend_r <= 1'b0;
        end else if (data_write_strobe) begin
            write_pend_r <= 1'b1;
        end else if (hs_end && cyc_wr_r) begin
            write_pend_r <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (internal_clear) begin
            read_pend_r <= 1'b0;
        end else if (read_request) begin
            read_pend_r <= 1'b1;
        end else if (hs_end && !cyc_wr_r) begin
            read_pend_r <= 1'b0;
        end
    end

    // select lines load as a bus cycle starts or on a clear, which also ends any cycle
    logic select_load_strobe;
    logic [NUM_SEL-1:0] sel_lines_r;
    assign select_load_strobe = hs_start | internal_clear;
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            sel_lines_r <= decode_sel(SEL_RESET);
        end else if (select_load_strobe) begin
            sel_lines_r <= decode_sel(sel_code_r);
        end
    end
    assign system_select_lines_n = ~sel_lines_r;

    // data registers
    logic [DATA_W-1:0] out_data_r, in_data_r;
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            out_data_r <= DATA_RESET;
        end else if (data_write_strobe) begin
            out_data_r <= wr_word;
        end
    end
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            in_data_r <= DATA_RESET;
        end else if (bus_read_strobe && ack_d_r) begin
            in_data_r <= bus_data_in;
        end
    end
    assign bus_data_out = out_data_r;
    assign bus_data_drive_enable = bus_write_strobe;
    assign bus_write_line_n = ~bus_write_strobe;
    assign bus_read_line_n = ~bus_read_strobe;

    // ready and interrupts
    logic busy, cpu_ready, ready_d_r;
    assign busy = write_pend_r | read_pend_r | (hs_state_r != CDB_IDLE) | ack;
    assign cpu_ready = ~(busy | internal_clear);
    assign cpu_ready_n = ~cpu_ready;

    logic [NUM_SYS_INT-1:0] edge_latch, edge_pulse, int_flag_r;
    logic ready_interrupt;
    // one detector per line; its latch is frozen during a cpu read so no edge is lost
    for (genvar g = 0; g < NUM_SYS_INT; g++) begin : g_int
        logic latch_r, flag_r;
        always_ff @(posedge sys_clk) begin
            if (internal_clear) begin
                latch_r <= 1'b0;
            end else if (!cpu_read_active) begin
                latch_r <= int_s2_r[g];
            end
        end
        always_ff @(posedge sys_clk) begin
            if (internal_clear || status_read_done) begin
                flag_r <= 1'b0;
            end else if (!cpu_read_active && edge_pulse[g]) begin
                flag_r <= 1'b1;
            end
        end
        assign edge_latch[g] = latch_r;
        assign edge_pulse[g] = int_s2_r[g] & ~edge_latch[g];
        assign int_flag_r[g] = flag_r;
    end
    always_ff @(posedge sys_clk) begin
        ready_d_r <= cpu_ready;
    end
    always_ff @(posedge sys_clk) begin
        if (internal_clear || status_read_done) begin
            ready_interrupt <= 1'b0;
        end else if (cpu_ready && !ready_d_r && !cpu_read_active) begin
            ready_interrupt <= 1'b1;
        end
    end
    logic common_interrupt;
    assign common_interrupt = |int_flag_r;
    assign cpu_int = (common_interrupt & common_interrupt_enable)
        | (ready_interrupt & ready_interrupt_enable);

    // status word and read mux
    logic [DATA_W-1:0] status_word, cpu_word;
    always_comb begin
        status_word = '0;
        status_word[STS_SEL_LSB +: SEL_W] = sel_code_r;
        status_word[STS_PRE_BIT] = prefetch_bit;
        status_word[STS_RDY_IE_BIT] = ready_interrupt_enable;
        status_word[STS_IE_LSB +: 3] = ctrl_r[3:1];
        status_word[STS_RDY_INT_BIT] = ready_interrupt;
        status_word[STS_READY_BIT] = cpu_ready;
        status_word[STS_INT_LSB +: NUM_SYS_INT] = int_flag_r;
    end
    // the qualifier is synchronised too, so the word cannot swap under a read
    assign cpu_word = cmd_s2_r ? status_word : in_data_r;
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            cpu_data_out <= DATA_RESET;
            cpu_data_oe <= 1'b0;
        end else begin
            cpu_data_out <= cpu_word;
            cpu_data_oe <= read_sync_stage1;
        end
    end

    // avalon slave: writes single cycle, reads take one wait cycle
    logic rd_wait_r;
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rd_wait_r <= 1'b0;
        end else begin
            rd_wait_r <= avs_read & ~rd_wait_r;
        end
    end

    // read data stands until the next read is taken
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            avs_readdata <= 32'h00000000;
        end else if (avs_read && !rd_wait_r) begin
            case (avs_address)
                OFS_COMMAND: avs_readdata <= {26'h0, ctrl_r};
                OFS_STATUS: avs_readdata <= {16'h0000, status_word};
                OFS_DATA: avs_readdata <= {16'h0000, in_data_r};
                OFS_SELECT: avs_readdata <= {24'h000000, sel_lines_r};
                default: avs_readdata <= 32'h00000000;
            endcase
        end
    end
    assign avs_waitrequest = avs_read & ~rd_wait_r;
endmodule

// ===== verif/cdb_bridge_assertions.sv
module cdb_bridge_assertions (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic cpu_read_n,
    input wire logic cpu_data_oe,
    input wire logic cpu_ready_n,
    input wire logic bus_data_drive_enable,
    input wire logic bus_write_line_n,
    input wire logic bus_read_line_n,
    input wire logic bus_acknowledge_n,
    input wire logic [cdb_pkg::NUM_SEL-1:0] system_select_lines_n,
    input wire logic programmed_clear_n
);
    timeunit 1ns;
    timeprecision 1ps;
    import cdb_pkg::*;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    sequence s_wr_acked;
        !bus_write_line_n && !bus_acknowledge_n;
    endsequence
    sequence s_rd_acked;
        !bus_read_line_n && !bus_acknowledge_n;
    endsequence
    AST_SEL_ONEHOT: assert property ($onehot(~system_select_lines_n))
        else $error("select lines not one-hot");
    AST_SEL_RESET: assert property ($fell(rst) |-> system_select_lines_n == 8'hFE)
        else $error("select line zero not alone after reset");
    AST_CLR_POWERUP: assert property ($fell(rst) |-> ##[0:17] programmed_clear_n)
        else $error("programmed clear not over after reset");
    AST_RDY_CLEAR: assert property (!programmed_clear_n |-> cpu_ready_n)
        else $error("ready during clear");
    AST_RDY_BUSY: assert property ((!bus_acknowledge_n || !bus_write_line_n ||
        !bus_read_line_n) |-> cpu_ready_n)
        else $error("ready during bus cycle");
    AST_WR_DRIVE: assert property (!bus_write_line_n |-> bus_data_drive_enable)
        else $error("write line without data drive");
    AST_WR_START: assert property ($fell(bus_write_line_n) |-> $past(bus_acknowledge_n))
        else $error("write started while acknowledge busy");
    AST_WR_RELEASE: assert property (s_wr_acked |-> ##[1:2] bus_write_line_n)
        else $error("write line not released after acknowledge");
    AST_RD_RELEASE: assert property (s_rd_acked |-> ##[1:2] bus_read_line_n)
        else $error("read line not released after acknowledge");
    AST_OE_READ: assert property (cpu_data_oe |-> !($past(cpu_read_n, 1) &&
        $past(cpu_read_n, 2) && $past(cpu_read_n, 3)))
        else $error("cpu bus driven outside a read");
endmodule

// ===== verif/cdb_disp_model.sv
module cdb_disp_model (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic slow,
    input wire logic bus_write_line_n,
    input wire logic bus_read_line_n,
    input wire logic [cdb_pkg::DATA_W-1:0] bus_data_out,
    input wire logic bus_data_drive_enable,
    output logic [cdb_pkg::DATA_W-1:0] bus_data_in,
    output logic bus_acknowledge_n,
    output logic [cdb_pkg::DATA_W-1:0] last_wr,
    output logic [cdb_pkg::DATA_W-1:0] next_rd
);
    timeunit 1ns;
    timeprecision 1ps;
    import cdb_pkg::*;
    logic rd_r;
    int wait_cnt;
    // released data lines float to the pull-up level
    assign bus_data_in = (!bus_acknowledge_n && rd_r) ? next_rd : 16'hFFFF;
    always @(posedge sys_clk) begin
        if (rst) begin
            bus_acknowledge_n <= 1'b1;
            rd_r <= 1'b0;
            wait_cnt <= 0;
            next_rd <= 16'hA5C0;
            last_wr <= 16'h0000;
        end else if (bus_acknowledge_n) begin
            if (!bus_write_line_n || !bus_read_line_n) begin
                wait_cnt <= wait_cnt + 1;
                if (wait_cnt >= (slow ? 4 : 0)) begin
                    bus_acknowledge_n <= 1'b0;
                    wait_cnt <= 0;
                    rd_r <= !bus_read_line_n;
                    // data must be valid and driven while write is asserted
                    last_wr <= bus_data_drive_enable ? bus_data_out : ~bus_data_out;
                end
            end
        end else if (bus_write_line_n && bus_read_line_n) begin
            // acknowledge outlasts the strobe by at least one clock
            wait_cnt <= wait_cnt + 1;
            if (wait_cnt >= 1) begin
                bus_acknowledge_n <= 1'b1;
                wait_cnt <= 0;
                if (rd_r) next_rd <= next_rd + 16'h0001;
                rd_r <= 1'b0;
            end
        end
    end
endmodule

// ===== verif/cdb_bridge_tb.sv
module cdb_bridge_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import cdb_pkg::*;
    logic sys_clk = 1'b0, rst = 1'b1, avs_read = 1'b0, avs_write = 1'b0, slow = 1'b0;
    logic cpu_write_n = 1'b1, cpu_read_n = 1'b1, cpu_cmd_n = 1'b1;
    logic [3:0] avs_address = 4'h0;
    logic [31:0] avs_writedata = 32'h0, avs_readdata, d;
    logic avs_waitrequest, cpu_data_oe, cpu_ready_n, cpu_int, bus_de, bus_wr_n, bus_rd_n;
    logic bus_ack_n, prog_clr_n, saw_clr;
    logic [15:0] cpu_data_in = 16'h0, cpu_data_out, bus_in, bus_out, last_wr, next_rd;
    logic [7:0] sel_n;
    logic [3:0] sys_int_n = 4'hF;
    int error_cnt = 0, checks_done = 0, cycles = 0;
    always #5 sys_clk = ~sys_clk;
    cdb_bridge dut_u (.sys_clk(sys_clk), .rst(rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .cpu_write_n(cpu_write_n), .cpu_read_n(cpu_read_n), .cpu_cmd_n(cpu_cmd_n),
        .cpu_data_in(cpu_data_in), .cpu_data_out(cpu_data_out), .cpu_data_oe(cpu_data_oe),
        .cpu_ready_n(cpu_ready_n), .cpu_int(cpu_int), .bus_data_in(bus_in),
        .bus_data_out(bus_out), .bus_data_drive_enable(bus_de), .bus_write_line_n(bus_wr_n),
        .bus_read_line_n(bus_rd_n), .bus_acknowledge_n(bus_ack_n),
        .system_select_lines_n(sel_n), .sys_int_n(sys_int_n), .programmed_clear_n(prog_clr_n));
    cdb_disp_model disp_u (.sys_clk(sys_clk), .rst(rst), .slow(slow),
        .bus_write_line_n(bus_wr_n), .bus_read_line_n(bus_rd_n), .bus_data_out(bus_out),
        .bus_data_drive_enable(bus_de), .bus_data_in(bus_in), .bus_acknowledge_n(bus_ack_n),
        .last_wr(last_wr), .next_rd(next_rd));
    task automatic summarize();
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // the master holds the request until it samples waitrequest low
    task automatic av_xfer(input logic wr, input logic [3:0] a, input logic [31:0] wd);
        avs_address <= a;
        avs_writedata <= wd;
        avs_read <= !wr;
        avs_write <= wr;
        // only the bench timeout ends this wait
        do begin
            @(posedge sys_clk);
        end while (avs_waitrequest !== 1'b0);
        d = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge sys_clk);
    endtask
    task automatic wait_ready();
        int i;
        for (i = 0; cpu_ready_n !== 1'b0 && i < 300; i++)
            @(posedge sys_clk);
        if (cpu_ready_n !== 1'b0) chk("cpu_ready_n", cpu_ready_n, 0);
    endtask
    // pin strobes are held well past the two synchroniser stages
    task automatic cpu_xfer(input logic wr, input logic cmd_n, input logic [15:0] wd);
        wait_ready();
        cpu_cmd_n <= cmd_n;
        cpu_data_in <= wd;
        cpu_write_n <= !wr;
        cpu_read_n <= wr;
        repeat (CPU_HOLD_CYCLES + 4) @(posedge sys_clk);
        d = cpu_data_oe === 1'b1 ? {16'h0, cpu_data_out} : 32'hX;
        cpu_write_n <= 1'b1;
        cpu_read_n <= 1'b1;
        repeat (6) @(posedge sys_clk);
    endtask
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles >= 20000) begin
            error_cnt++;
            summarize();
        end
    end
    initial begin
        repeat (16) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        chk("sel_n reset", sel_n, 8'hFE);
        cpu_xfer(1, 0, 16'h02C0);
        av_xfer(0, OFS_STATUS, 0);
        chk("sel code", d[15:13], 3);
        cpu_xfer(1, 0, 16'h0940);
        av_xfer(0, OFS_STATUS, 0);
        chk("sel kept, enable loaded", {d[15:13], d[8]}, 4'h7);
        cpu_xfer(1, 1, 16'h1234);
        wait_ready();
        chk("written word", last_wr, 16'h1234);
        chk("select lines", sel_n, 8'hF7);
        slow <= 1'b1;
        cpu_xfer(1, 0, 16'h0C00);
        av_xfer(0, OFS_STATUS, 0);
        chk("status busy", d[STS_READY_BIT], 0);
        cpu_xfer(0, 1, 0);
        chk("prefetched word", d, 16'hA5C0);
        cpu_xfer(0, 1, 0);
        chk("next word", d, 16'hA5C1);
        wait_ready();
        av_xfer(0, OFS_STATUS, 0);
        chk("status ready", d[STS_READY_BIT], 1);
        sys_int_n[0] <= 1'b0;
        repeat (4) @(posedge sys_clk);
        chk("cpu_int set", cpu_int, 1);
        cpu_xfer(0, 0, 0);
        chk("status int flag", d[0], 1);
        chk("cpu_int cleared", cpu_int, 0);
        cpu_xfer(1, 0, 16'h0000);
        sys_int_n[1] <= 1'b0;
        repeat (4) @(posedge sys_clk);
        chk("cpu_int masked", cpu_int, 0);
        av_xfer(0, OFS_STATUS, 0);
        chk("masked flag", d[1], 1);
        cpu_xfer(0, 0, 0);
        cpu_xfer(1, 0, 16'h4000);
        cpu_xfer(1, 1, 16'hBEEF);
        wait_ready();
        // the flag sets on the edge at which ready is first seen high
        @(posedge sys_clk);
        chk("ready int", cpu_int, 1);
        chk("written word 2", last_wr, 16'hBEEF);
        cpu_write_n <= 1'b0;
        cpu_cmd_n <= 1'b0;
        cpu_data_in <= 16'h8380;
        saw_clr = 1'b0;
        repeat (20) begin
            @(posedge sys_clk);
            cpu_write_n <= 1'b1;
            saw_clr |= (prog_clr_n === 1'b0);
        end
        chk("programmed clear", saw_clr, 1);
        wait_ready();
        av_xfer(0, OFS_STATUS, 0);
        chk("sel after clear", d[15:13], 0);
        av_xfer(0, OFS_SELECT, 0);
        chk("select lines read", d, 32'h1);
        av_xfer(1, OFS_COMMAND, 32'h0380);
        av_xfer(0, OFS_STATUS, 0);
        chk("sel via avalon", d[15:13], 6);
        av_xfer(1, 4'h2, 32'hFFFF);
        av_xfer(0, 4'h2, 0);
        chk("unmapped read", d, 0);
        summarize();
    end
endmodule
bind cdb_bridge cdb_bridge_assertions chk_u (.sys_clk(sys_clk), .rst(rst),
    .cpu_read_n(cpu_read_n), .cpu_data_oe(cpu_data_oe), .cpu_ready_n(cpu_ready_n),
    .bus_data_drive_enable(bus_data_drive_enable), .bus_write_line_n(bus_write_line_n),
    .bus_read_line_n(bus_read_line_n), .bus_acknowledge_n(bus_acknowledge_n),
    .system_select_lines_n(system_select_lines_n), .programmed_clear_n(programmed_clear_n));
